//--- lk_defines.svh
`ifndef LK_DEFINES_SVH
`define LK_DEFINES_SVH

// ----------------------------------------
// Bus encodings and timing counts
// ----------------------------------------
`define LK_CMD_MEM_RD 4'h6
`define LK_MABORT_CYC 5
`define LK_DEC_CYC 2
`define LK_CNT_W 4
`define LK_CNT_ONE 4'h1
`define LK_CNT_ZERO 4'h0
`define LK_BASE_DEF 32'h1000_0000
`define LK_MASK_DEF 32'hF000_0000

`endif

//--- lk_pkg.sv
`default_nettype none

package lk_pkg;
    typedef enum logic [2:0] {LK_OK, LK_DISC, LK_RETRY, LK_MABORT, LK_TABORT, LK_NOOWN} lk_stat_t;
    typedef enum logic [1:0] {LK_UNLK, LK_TLOCK, LK_FLOCK} lk_lock_st_t;
    typedef enum {M_IDLE, M_WAIT, M_REQ, M_ADDR, M_DATA, M_TURN, M_GAP} lk_mst_st_t;
    typedef enum {T_IDLE, T_DEC, T_RESP, T_TURN} lk_tgt_st_t;
endpackage

`default_nettype wire

//--- lk_bus_if.sv
`default_nettype none

interface lk_bus_if;
    // ----------------------------------------
    // Master end drives
    // ----------------------------------------
    logic m_oe;
    logic m_frame_n;
    logic m_irdy_n;
    logic [3:0] m_cmd;
    logic [31:0] m_ad;
    logic m_lock_oe;
    logic m_lock_n;
    logic m_req_n;
    logic m_gnt_n;
    // ----------------------------------------
    // Bridge target end drives
    // ----------------------------------------
    logic t_oe;
    logic t_devsel_n;
    logic t_trdy_n;
    logic t_stop_n;
    // ----------------------------------------
    // Other agents, driven by the bench
    // ----------------------------------------
    logic x_frame_n;
    logic x_irdy_n;
    logic x_lock_n;
    logic [3:0] x_cmd;
    logic [31:0] x_ad;
    // ----------------------------------------
    // Resolved bus, undriven lines pulled high
    // ----------------------------------------
    wire logic frame_n = (m_oe ? m_frame_n : 1'b1) & x_frame_n;
    wire logic irdy_n = (m_oe ? m_irdy_n : 1'b1) & x_irdy_n;
    wire logic lock_n = (m_lock_oe ? m_lock_n : 1'b1) & x_lock_n;
    wire logic [3:0] cmd = m_oe ? m_cmd : x_cmd;
    wire logic [31:0] ad = m_oe ? m_ad : x_ad;
    wire logic devsel_n = t_oe ? t_devsel_n : 1'b1;
    wire logic trdy_n = t_oe ? t_trdy_n : 1'b1;
    wire logic stop_n = t_oe ? t_stop_n : 1'b1;

    modport mst (
        output m_oe, m_frame_n, m_irdy_n, m_cmd, m_ad, m_lock_oe, m_lock_n, m_req_n, m_gnt_n,
        input frame_n, irdy_n, lock_n, devsel_n, trdy_n, stop_n
    );
    modport tgt (
        output t_oe, t_devsel_n, t_trdy_n, t_stop_n,
        input frame_n, irdy_n, lock_n, cmd, ad
    );
endinterface

`default_nettype wire

//--- lk_tgt.sv
`include "lk_defines.svh"
`default_nettype none

module lk_tgt
    import lk_pkg::*;
#(
    parameter logic [31:0] BASE = `LK_BASE_DEF,
    parameter logic [31:0] MASK = `LK_MASK_DEF,
    parameter int DEC_CYC = `LK_DEC_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // Shared bus
    lk_bus_if.tgt bus,
    // Delayed transaction side
    input wire logic sec_est_i,
    input wire logic dt_ready_i,
    output logic dt_enq_o,
    output logic sec_lock_o,
    output logic xfer_o,
    output lk_lock_st_t lock_st_o
);
    lk_tgt_st_t st_q;
    lk_lock_st_t lst_q;
    logic fr_q;
    logic lk_a_q;
    logic lk_b_q;
    logic lk_b;
    logic [31:0] adr_q;
    logic [31:0] orig_q;
    logic [`LK_CNT_W-1:0] cnt_q;
    logic oe_q, devsel_n_q, trdy_n_q, stop_n_q;
    logic addr_ph, dec_done, lreq, repeat_ok, do_retry, data_ev, enter_tl;

    // ----------------------------------------
    // Decode and response decision
    // ----------------------------------------
    assign addr_ph = !bus.frame_n && fr_q;
    assign lk_b = (cnt_q == `LK_CNT_ZERO) ? !bus.lock_n : lk_b_q;
    assign dec_done = (st_q == T_DEC) && (cnt_q == `LK_CNT_W'(DEC_CYC - 1));
    assign lreq = !lk_a_q && lk_b;
    // Repeat only counts once the far side holds the lock
    assign repeat_ok = lreq && (adr_q == orig_q) && sec_lock_o && dt_ready_i;
    assign do_retry = ((lst_q != LK_UNLK) && lk_a_q)
        || ((lst_q == LK_TLOCK) && !repeat_ok)
        || ((lst_q == LK_UNLK) && lreq);
    assign enter_tl = dec_done && (lst_q == LK_UNLK) && lreq;
    assign data_ev = (st_q == T_RESP) && !bus.irdy_n && !trdy_n_q;

    assign bus.t_oe = oe_q;
    assign bus.t_devsel_n = devsel_n_q;
    assign bus.t_trdy_n = trdy_n_q;
    assign bus.t_stop_n = stop_n_q;
    assign lock_st_o = lst_q;

    // ----------------------------------------
    // Transaction sequencing
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_q <= T_IDLE;
            fr_q <= 1'b1;
            lk_a_q <= 1'b0;
            lk_b_q <= 1'b0;
            adr_q <= '0;
            cnt_q <= `LK_CNT_ZERO;
            oe_q <= 1'b0;
            devsel_n_q <= 1'b1;
            trdy_n_q <= 1'b1;
            stop_n_q <= 1'b1;
        end else begin
            fr_q <= bus.frame_n;
            case (st_q)
                T_IDLE: begin
                    if (addr_ph && ((bus.ad & MASK) == BASE)) begin
                        lk_a_q <= !bus.lock_n;
                        adr_q <= bus.ad;
                        cnt_q <= `LK_CNT_ZERO;
                        st_q <= T_DEC;
                    end
                end
                T_DEC: begin
                    if (cnt_q == `LK_CNT_ZERO) begin
                        lk_b_q <= !bus.lock_n;
                    end
                    cnt_q <= cnt_q + `LK_CNT_ONE;
                    if (dec_done) begin
                        oe_q <= 1'b1;
                        devsel_n_q <= 1'b0;
                        trdy_n_q <= do_retry;
                        stop_n_q <= 1'b0;
                        st_q <= T_RESP;
                    end
                end
                T_RESP: begin
                    if (!bus.irdy_n) begin
                        devsel_n_q <= 1'b1;
                        trdy_n_q <= 1'b1;
                        stop_n_q <= 1'b1;
                        st_q <= T_TURN;
                    end
                end
                T_TURN: begin
                    oe_q <= 1'b0;
                    st_q <= T_IDLE;
                end
                default: st_q <= T_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Lock state
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            lst_q <= LK_UNLK;
            orig_q <= '0;
            sec_lock_o <= 1'b0;
            dt_enq_o <= 1'b0;
            xfer_o <= 1'b0;
        end else begin
            dt_enq_o <= enter_tl;
            xfer_o <= data_ev;
            if (enter_tl) begin
                lst_q <= LK_TLOCK;
                orig_q <= adr_q;
            end else if (data_ev && (lst_q == LK_TLOCK)) begin
                lst_q <= LK_FLOCK;
            end else if (bus.frame_n && bus.lock_n) begin
                lst_q <= LK_UNLK;
            end
            if (bus.frame_n && bus.lock_n && !enter_tl) begin
                sec_lock_o <= 1'b0;
            end else if ((lst_q == LK_TLOCK) && sec_est_i) begin
                sec_lock_o <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

//--- lk_mst.sv
`include "lk_defines.svh"
`default_nettype none

// Overview of operation
// - Track foreign lock busy until frame, lock idle
// - Hold off request while lock is busy
// - Drop request if lock turns busy
// - Grant with idle lock gives ownership
// - Memory read, lock asserted after address
// - Lock established on first completed data
// - Retry on first access releases lock
// - Keep lock across retry and disconnect
// - Locked bridge retries lock-asserted addresses
// - Bridge unlocks when frame, lock idle
// - Locked bridge passes no foreign traffic
// - Delayed locked request enters target-lock
// - Target-lock retries all new requests
// - Secondary lock then watch for repeat
// - Sample lock at address and next
// - Target-lock only on deassert-then-assert lock
// - Continue: lock high address, then reassert
// - Release lock with irdy after last
// - One idle clock between exclusive operations
// - Bus lock retry drops request, lock
// - Bus lock arbiter withholds other grants
module lk_mst
    import lk_pkg::*;
#(
    parameter int MABORT_CYC = `LK_MABORT_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // Shared bus
    lk_bus_if.mst bus,
    // Access request
    input wire logic op_start_i,
    input wire logic op_first_i,
    input wire logic op_last_i,
    input wire logic [3:0] op_cmd_i,
    input wire logic [31:0] op_addr_i,
    // Arbiter
    input wire logic cbl_en_i,
    input wire logic oth_req_i,
    output logic oth_gnt_o,
    // Status
    output logic op_busy_o,
    output logic op_done_o,
    output lk_stat_t op_stat_o,
    output logic lock_own_o,
    output logic lock_est_o
);
    lk_mst_st_t st_q;
    logic busy_q;
    logic first_q, last_q, rel_q;
    logic [3:0] cmd_q;
    logic [31:0] addr_q;
    logic [`LK_CNT_W-1:0] dcnt_q;
    logic oe_q, frame_n_q, irdy_n_q, lock_oe_q, lock_n_q, req_n_q, gnt_n_q;
    logic [3:0] bcmd_q;
    logic [31:0] bad_q;
    logic blocked, gnt_take, own_win, data_ok, tgt_stop, retry, t_abort, m_abort, hold;

    // ----------------------------------------
    // Bus event decode
    // ----------------------------------------
    assign blocked = busy_q && !lock_own_o;
    assign gnt_take = (st_q == M_REQ) && !gnt_n_q && !blocked && bus.frame_n && bus.irdy_n;
    assign own_win = lock_own_o || (first_q && !busy_q);
    assign data_ok = (st_q == M_DATA) && !bus.devsel_n && !bus.trdy_n;
    assign tgt_stop = (st_q == M_DATA) && !bus.stop_n && bus.trdy_n;
    assign retry = tgt_stop && !bus.devsel_n;
    assign t_abort = tgt_stop && bus.devsel_n;
    assign m_abort = (st_q == M_DATA) && bus.devsel_n && (dcnt_q == `LK_CNT_W'(MABORT_CYC));
    // Bus lock only after the first locked data phase
    assign hold = cbl_en_i && lock_est_o && !bus.lock_n;

    assign bus.m_oe = oe_q;
    assign bus.m_frame_n = frame_n_q;
    assign bus.m_irdy_n = irdy_n_q;
    assign bus.m_cmd = bcmd_q;
    assign bus.m_ad = bad_q;
    assign bus.m_lock_oe = lock_oe_q;
    assign bus.m_lock_n = lock_n_q;
    assign bus.m_req_n = req_n_q;
    assign bus.m_gnt_n = gnt_n_q;

    // ----------------------------------------
    // Lock busy tracking
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            busy_q <= 1'b0;
        end else if (bus.frame_n && bus.lock_n) begin
            busy_q <= 1'b0;
        end else if (!bus.lock_n && !lock_own_o) begin
            busy_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Ownership and establishment
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            lock_own_o <= 1'b0;
            lock_est_o <= 1'b0;
        end else if ((st_q == M_TURN) && rel_q) begin
            lock_own_o <= 1'b0;
            lock_est_o <= 1'b0;
        end else begin
            if (gnt_take && first_q && !busy_q) begin
                lock_own_o <= 1'b1;
            end
            if (data_ok && first_q && lock_own_o) begin
                lock_est_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Arbiter with optional complete bus lock
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            gnt_n_q <= 1'b1;
            oth_gnt_o <= 1'b0;
        end else if (hold) begin
            gnt_n_q <= req_n_q;
            oth_gnt_o <= 1'b0;
        end else if (!req_n_q) begin
            gnt_n_q <= 1'b0;
            oth_gnt_o <= 1'b0;
        end else begin
            gnt_n_q <= 1'b1;
            oth_gnt_o <= oth_req_i;
        end
    end

    // ----------------------------------------
    // Access sequencing
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_q <= M_IDLE;
            first_q <= 1'b0;
            last_q <= 1'b0;
            rel_q <= 1'b0;
            cmd_q <= '0;
            addr_q <= '0;
            dcnt_q <= `LK_CNT_ZERO;
            oe_q <= 1'b0;
            frame_n_q <= 1'b1;
            irdy_n_q <= 1'b1;
            lock_oe_q <= 1'b0;
            lock_n_q <= 1'b1;
            req_n_q <= 1'b1;
            bcmd_q <= '0;
            bad_q <= '0;
            op_busy_o <= 1'b0;
            op_done_o <= 1'b0;
            op_stat_o <= LK_OK;
        end else begin
            op_done_o <= 1'b0;
            case (st_q)
                M_IDLE: begin
                    if (op_start_i) begin
                        first_q <= op_first_i;
                        last_q <= op_last_i;
                        cmd_q <= op_cmd_i;
                        addr_q <= op_addr_i;
                        rel_q <= 1'b0;
                        if (!op_first_i && !lock_own_o) begin
                            op_stat_o <= LK_NOOWN;
                            op_done_o <= 1'b1;
                        end else begin
                            op_busy_o <= 1'b1;
                            st_q <= M_WAIT;
                        end
                    end
                end
                M_WAIT: begin
                    if (!blocked) begin
                        req_n_q <= 1'b0;
                        st_q <= M_REQ;
                    end
                end
                M_REQ: begin
                    if (blocked) begin
                        req_n_q <= 1'b1;
                        st_q <= M_WAIT;
                    end else if (gnt_take) begin
                        req_n_q <= 1'b1;
                        oe_q <= 1'b1;
                        frame_n_q <= 1'b0;
                        bcmd_q <= first_q ? `LK_CMD_MEM_RD : cmd_q;
                        bad_q <= addr_q;
                        lock_oe_q <= own_win;
                        lock_n_q <= 1'b1;
                        dcnt_q <= `LK_CNT_ZERO;
                        st_q <= M_ADDR;
                    end
                end
                M_ADDR: begin
                    // Single data phase per access keeps retry handling local
                    frame_n_q <= 1'b1;
                    irdy_n_q <= 1'b0;
                    lock_n_q <= !lock_oe_q;
                    st_q <= M_DATA;
                end
                M_DATA: begin
                    dcnt_q <= dcnt_q + `LK_CNT_ONE;
                    if (data_ok) begin
                        irdy_n_q <= 1'b1;
                        op_stat_o <= bus.stop_n ? LK_OK : LK_DISC;
                        if (last_q) begin
                            lock_n_q <= 1'b1;
                            rel_q <= 1'b1;
                        end
                        st_q <= M_TURN;
                    end else if (retry) begin
                        irdy_n_q <= 1'b1;
                        op_stat_o <= LK_RETRY;
                        if (!lock_est_o) begin
                            lock_n_q <= 1'b1;
                            rel_q <= 1'b1;
                        end
                        st_q <= M_TURN;
                    end else if (t_abort || m_abort) begin
                        irdy_n_q <= 1'b1;
                        lock_n_q <= 1'b1;
                        rel_q <= 1'b1;
                        op_stat_o <= t_abort ? LK_TABORT : LK_MABORT;
                        st_q <= M_TURN;
                    end
                end
                M_TURN: begin
                    oe_q <= 1'b0;
                    lock_oe_q <= lock_own_o && !rel_q;
                    op_done_o <= 1'b1;
                    op_busy_o <= 1'b0;
                    st_q <= rel_q ? M_GAP : M_IDLE;
                end
                M_GAP: begin
                    // Idle clock so a locked target sees frame and lock released
                    st_q <= M_IDLE;
                end
                default: st_q <= M_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

//--- lk_sva.sv
`include "lk_defines.svh"
`default_nettype none

module lk_sva (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // Master end
    input wire logic m_oe,
    input wire logic m_frame_n,
    input wire logic m_irdy_n,
    input wire logic [3:0] m_cmd,
    input wire logic m_lock_oe,
    input wire logic m_lock_n,
    input wire logic m_req_n,
    input wire logic m_gnt_n,
    // Other agents and resolved lines
    input wire logic x_lock_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic lock_n,
    input wire logic devsel_n,
    input wire logic trdy_n,
    input wire logic stop_n
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // ----------------------------------------
    // Foreign lock tracking
    // ----------------------------------------
    logic busy_q;
    always_ff @(posedge mclk_i) begin
        if (srst_i)
            busy_q <= 1'b0;
        else if (!x_lock_n)
            busy_q <= 1'b1;
        else if (frame_n && lock_n)
            busy_q <= 1'b0;
    end

    sequence s_lock_req;
        $fell(m_frame_n) && m_lock_oe;
    endsequence
    sequence s_first_retry;
        $rose(m_lock_oe) ##[1:8] (!stop_n && trdy_n && !irdy_n);
    endsequence

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    addr_unlocked_a: assert property (s_lock_req |-> m_lock_n)
        else $error("lock asserted in address phase");
    lock_next_a: assert property (s_lock_req |=> !m_lock_n)
        else $error("lock not asserted after address");
    first_memrd_a: assert property ($rose(m_lock_oe) |-> !m_frame_n && m_cmd == `LK_CMD_MEM_RD)
        else $error("first locked access not a memory read");
    grant_own_a: assert property ($rose(m_lock_oe) |-> !$past(m_gnt_n))
        else $error("lock driven without grant");
    idle_gap_a: assert property ($rose(m_lock_oe) |-> $past(frame_n) && $past(lock_n))
        else $error("no idle clock before lock request");
    busy_hold_a: assert property (busy_q |=> m_req_n)
        else $error("request while lock busy");
    retry_release_a: assert property (s_first_retry |-> ##[1:2] !m_lock_oe)
        else $error("lock kept after first retry");
    lock_kept_a: assert property (m_oe && !m_irdy_n && m_lock_oe |-> !m_lock_n)
        else $error("lock dropped during data phase");
    tgt_hold_a: assert property (!devsel_n && irdy_n |=> !devsel_n && !stop_n)
        else $error("target response not held");
    tgt_release_a: assert property (!devsel_n && !irdy_n |=> devsel_n && trdy_n && stop_n)
        else $error("target response not released");
endmodule

`default_nettype wire

//--- testbench.sv
`include "lk_defines.svh"
`default_nettype none

module testbench
    import lk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [31:0] addr; logic la; logic ln; logic hold; logic sec; logic rdy;
        logic trdy; lk_lock_st_t st;} lk_row_t;
    localparam logic [31:0] ADR = 32'h1000_0040;
    logic mclk_i, srst_i, op_start_i, op_first_i, op_last_i, cbl_en_i, oth_req_i;
    logic sec_est_i, dt_ready_i, oth_gnt_o, op_busy_o, op_done_o, lock_own_o, lock_est_o;
    logic dt_enq_o, sec_lock_o, xfer_o;
    logic [3:0] op_cmd_i;
    logic [31:0] op_addr_i;
    lk_stat_t op_stat_o;
    lk_lock_st_t lock_st_o;
    int fails = 0, checks = 0, cyc = 0, enq_n = 0;
    // Foreign transactions: addr, lock at addr, lock next, hold, sec, ready, trdy, state
    lk_row_t rows [6] = '{
        '{ADR, 1, 1, 0, 0, 0, 0, LK_UNLK},
        '{ADR, 1, 0, 1, 0, 0, 1, LK_TLOCK},
        '{ADR, 0, 0, 1, 0, 0, 1, LK_TLOCK},
        '{ADR, 1, 0, 1, 1, 1, 0, LK_FLOCK},
        '{ADR, 0, 0, 1, 1, 1, 1, LK_FLOCK},
        '{ADR, 1, 0, 0, 1, 1, 0, LK_UNLK}};

    lk_bus_if bus();
    lk_mst u_lk_mst (.mclk_i, .srst_i, .bus(bus), .op_start_i, .op_first_i, .op_last_i, .op_cmd_i,
        .op_addr_i, .cbl_en_i, .oth_req_i, .oth_gnt_o, .op_busy_o, .op_done_o, .op_stat_o,
        .lock_own_o, .lock_est_o);
    lk_tgt u_lk_tgt (.mclk_i, .srst_i, .bus(bus), .sec_est_i, .dt_ready_i, .dt_enq_o, .sec_lock_o,
        .xfer_o, .lock_st_o);
    lk_sva u_lk_sva (.mclk_i, .srst_i, .m_oe(bus.m_oe), .m_frame_n(bus.m_frame_n),
        .m_irdy_n(bus.m_irdy_n), .m_cmd(bus.m_cmd), .m_lock_oe(bus.m_lock_oe), .m_lock_n(bus.m_lock_n),
        .m_req_n(bus.m_req_n), .m_gnt_n(bus.m_gnt_n), .x_lock_n(bus.x_lock_n), .frame_n(bus.frame_n),
        .irdy_n(bus.irdy_n), .lock_n(bus.lock_n), .devsel_n(bus.devsel_n), .trdy_n(bus.trdy_n),
        .stop_n(bus.stop_n));

    // ----------------------------------------
    // Clock, watchdog and helpers
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (dt_enq_o === 1'b1)
            enq_n++;
        if (cyc == 4000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset;
        srst_i <= 1'b1;
        bus.x_lock_n <= 1'b1;
        repeat (6) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(negedge mclk_i);
        chk(lock_st_o, LK_UNLK);
        chk({op_busy_o, lock_own_o, lock_est_o, bus.lock_n}, 4'h1);
    endtask

    // Another agent runs one single-phase transaction
    task automatic fx(input lk_row_t r);
        int k;
        @(posedge mclk_i);
        sec_est_i <= r.sec;
        dt_ready_i <= r.rdy;
        repeat (2) @(posedge mclk_i);
        bus.x_frame_n <= 1'b0;
        bus.x_ad <= r.addr;
        bus.x_lock_n <= r.la;
        @(posedge mclk_i);
        bus.x_frame_n <= 1'b1;
        bus.x_irdy_n <= 1'b0;
        bus.x_lock_n <= r.ln;
        k = 0;
        do begin
            @(negedge mclk_i);
            k++;
        end while (bus.devsel_n !== 1'b0 && k < 12);
        chk(bus.trdy_n, r.trdy);
        chk(bus.stop_n, 1'b0);
        @(posedge mclk_i);
        bus.x_irdy_n <= 1'b1;
        if (!r.hold)
            bus.x_lock_n <= 1'b1;
        repeat (2) @(negedge mclk_i);
        chk(lock_st_o, r.st);
    endtask

    task automatic mstart(input logic first, input logic [31:0] addr);
        @(posedge mclk_i);
        op_start_i <= 1'b1;
        op_first_i <= first;
        op_addr_i <= addr;
        @(posedge mclk_i);
        op_start_i <= 1'b0;
    endtask

    task automatic mwait(input lk_stat_t st);
        int k;
        k = 0;
        do begin
            @(negedge mclk_i);
            k++;
        end while (op_done_o !== 1'b1 && k < 80);
        chk(op_stat_o, st);
        repeat (3) @(negedge mclk_i);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst_i = 1'b1;
        {op_start_i, op_first_i, op_last_i, cbl_en_i, oth_req_i, sec_est_i, dt_ready_i} = 7'h08;
        op_cmd_i = `LK_CMD_MEM_RD;
        op_addr_i = 32'h0;
        bus.x_frame_n = 1'b1;
        bus.x_irdy_n = 1'b1;
        bus.x_lock_n = 1'b1;
        bus.x_cmd = `LK_CMD_MEM_RD;
        bus.x_ad = 32'h0;
        do_reset();
        chk(op_stat_o, LK_OK);
        foreach (rows[i]) begin
            fx(rows[i]);
            $display("test row %0d done", i);
        end
        chk(enq_n, 1);
        @(posedge mclk_i);
        bus.x_lock_n <= 1'b0;
        mstart(1'b1, ADR);
        repeat (6) @(negedge mclk_i);
        chk(bus.m_req_n, 1'b1);
        @(posedge mclk_i);
        bus.x_lock_n <= 1'b1;
        mwait(LK_RETRY);
        chk({lock_own_o, lock_est_o, bus.m_lock_oe, enq_n[3:0]}, 7'h02);
        $display("test held lock retry done");
        mstart(1'b1, 32'h2000_0000);
        mwait(LK_MABORT);
        chk({lock_own_o, bus.lock_n}, 2'h1);
        mstart(1'b0, ADR);
        mwait(LK_NOOWN);
        $display("test abort and no owner done");
        @(posedge mclk_i);
        oth_req_i <= 1'b1;
        repeat (3) @(negedge mclk_i);
        chk(oth_gnt_o, 1'b1);
        @(posedge mclk_i);
        oth_req_i <= 1'b0;
        repeat (3) @(negedge mclk_i);
        chk(oth_gnt_o, 1'b0);
        fx(rows[1]);
        @(posedge mclk_i);
        do_reset();
        $display("test arbiter and reset done");
        give_verdict();
    end
endmodule

`default_nettype wire
